// ---- hdl/ipr_regs.svh ----
`ifndef IPR_REGS_SVH
`define IPR_REGS_SVH

// ****************************************************************
// Register map and field layout.
// ****************************************************************
`define IPR_ADDR_W      4
`define IPR_DATA_W      16
`define IPR_PRIO_OFS    4'h0
`define IPR_STAT_OFS    4'h1

// Priority field positions inside the priority word.
`define IPR_LVL_W       3
`define IPR_SER_LSB     0
`define IPR_ADC_LSB     4
`define IPR_DMA_LSB     8

// Status field positions inside the status word.
`define IPR_STAT_EN_LSB 0
`define IPR_STAT_RQ_LSB 4
`define IPR_STAT_GT_LSB 8

// Reset and special field values.
`define IPR_LVL_RST     3'h4
`define IPR_LVL_OFF     3'h0
`define IPR_RD_IDLE     16'h0000
`define IPR_NSRC        3

`endif

// ---- hdl/ipr_pkg.sv ----
`default_nettype none
`include "ipr_regs.svh"

// ****************************************************************
// Types shared by the priority register block.
// ****************************************************************
package ipr_pkg;

    // One priority level, 0 disables, 7 is the highest.
    typedef logic [`IPR_LVL_W-1:0] ipr_level_t;

    // Plain register port request from the CPU side.
    typedef struct packed {
        logic [`IPR_ADDR_W-1:0] addr;
        logic [`IPR_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } ipr_bus_t;

    // The three priority levels as seen by the arbiter.
    typedef struct packed {
        ipr_level_t dma_ch1_done_priority;
        ipr_level_t adc1_done_priority;
        ipr_level_t serial1_tx_priority;
    } ipr_prio_t;

endpackage
`default_nettype wire

// ---- hdl/ipr_field.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ipr_regs.svh"

// ****************************************************************
// One writable priority field with its enable decode.
// ****************************************************************
module ipr_field #(
    parameter int unsigned     LVL_W   = `IPR_LVL_W,
    parameter logic [LVL_W-1:0] RST_LVL = `IPR_LVL_RST
) (
    input  wire logic             clk_i,     // System clock.
    input  wire logic             rst_b_i,   // Async reset, low.
    input  wire logic             we_i,      // Field write strobe.
    input  wire logic [LVL_W-1:0] wdata_i,   // New level.
    output logic      [LVL_W-1:0] level_o,   // Stored level.
    output logic                  enabled_o  // Level is not zero.
);

    logic [LVL_W-1:0] level_ff;
    logic [LVL_W-1:0] nxt_level;
    logic             enabled_ff;
    logic             nxt_enabled;

    // Next level and enable; a zero level turns the source off.
    always_comb begin
        nxt_level = level_ff;
        if (we_i) begin
            nxt_level = wdata_i;
        end
        nxt_enabled = (nxt_level != '0);
    end

    // Register the level, loading the default level at reset.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_ff   <= RST_LVL;
            enabled_ff <= (RST_LVL != '0);
        end else begin
            level_ff   <= nxt_level;
            enabled_ff <= nxt_enabled;
        end
    end

    assign level_o   = level_ff;
    assign enabled_o = enabled_ff;

endmodule
`default_nettype wire

// ---- hdl/ipr_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ipr_regs.svh"

// Contract
// - A 3-bit field is a priority level; all ones is level 7, the highest.
// - Bits 6 to 4 hold the ADC1 conversion-complete priority.
// - Bits 2 to 0 hold the serial port 1 transmitter priority.
// - After reset every field holds binary 100, level 4.
// - Field value 001 gives the source the lowest active level, 1.
// - Field value 000 disables the source; it never requests service.

// ****************************************************************
// Interrupt priority register for three sources.
// ****************************************************************
module ipr_top (
    input  wire logic                  clk_i,      // System clock.
    input  wire logic                  rst_b_i,    // Async reset, low.
    input  wire ipr_pkg::ipr_bus_t     bus_i,      // Register request.
    output logic [`IPR_DATA_W-1:0]     rdata_o,    // Read data, next cycle.
    output ipr_pkg::ipr_prio_t         prio_o,     // Levels to arbiter.
    output logic [`IPR_NSRC-1:0]       enabled_o,  // Source not disabled.
    input  wire logic [`IPR_NSRC-1:0]  src_req_i,  // Raw source requests.
    output logic [`IPR_NSRC-1:0]       gated_req_o // Requests of live ones.
);
    import ipr_pkg::*;

    // Source index 0 is serial tx, 1 is ADC1, 2 is DMA channel 1.
    localparam int unsigned LSB_TAB [`IPR_NSRC] = '{
        `IPR_SER_LSB, `IPR_ADC_LSB, `IPR_DMA_LSB
    };

    ipr_level_t                level   [`IPR_NSRC];
    logic       [`IPR_NSRC-1:0] enabled;
    logic                      prio_we;
    logic [`IPR_DATA_W-1:0]    prio_word;
    logic [`IPR_DATA_W-1:0]    stat_word;
    logic [`IPR_DATA_W-1:0]    rdata_ff;
    logic [`IPR_DATA_W-1:0]    nxt_rdata;
    logic [`IPR_NSRC-1:0]      gated_ff;
    logic [`IPR_NSRC-1:0]      nxt_gated;

    // ************************************************************
    // Priority fields.
    // ************************************************************

    // A write touches only the three fields; other bits are dropped.
    assign prio_we = bus_i.wr && (bus_i.addr == `IPR_PRIO_OFS);

    // One field per source, each taking its own slice of the word.
    for (genvar i = 0; i < `IPR_NSRC; i++) begin : g_fld
        ipr_field #(
            .LVL_W   (`IPR_LVL_W),
            .RST_LVL (`IPR_LVL_RST)
        ) u_fld (
            .clk_i     (clk_i),
            .rst_b_i   (rst_b_i),
            .we_i      (prio_we),
            .wdata_i   (bus_i.wdata[LSB_TAB[i] +: `IPR_LVL_W]),
            .level_o   (level[i]),
            .enabled_o (enabled[i])
        );
    end

    // Levels go to the arbiter untouched; 7 outranks all others.
    assign prio_o.serial1_tx_priority   = level[0];
    assign prio_o.adc1_done_priority    = level[1];
    assign prio_o.dma_ch1_done_priority = level[2];
    assign enabled_o                    = enabled;

    // ************************************************************
    // Read words.
    // ************************************************************

    // Assemble both read words; unused bits stay zero.
    always_comb begin
        prio_word = `IPR_RD_IDLE;
        stat_word = `IPR_RD_IDLE;
        for (int k = 0; k < `IPR_NSRC; k++) begin
            prio_word[LSB_TAB[k] +: `IPR_LVL_W] = level[k];
        end
        stat_word[`IPR_STAT_EN_LSB +: `IPR_NSRC] = enabled;
        stat_word[`IPR_STAT_RQ_LSB +: `IPR_NSRC] = src_req_i;
        stat_word[`IPR_STAT_GT_LSB +: `IPR_NSRC] = gated_ff;
    end

    // Read data stand one cycle after the strobe and read zero else.
    always_comb begin
        if (!bus_i.rd) begin
            nxt_rdata = `IPR_RD_IDLE;
        end else if (bus_i.addr == `IPR_PRIO_OFS) begin
            nxt_rdata = prio_word;
        end else if (bus_i.addr == `IPR_STAT_OFS) begin
            nxt_rdata = stat_word;
        end else begin
            nxt_rdata = `IPR_RD_IDLE;
        end
    end

    // ************************************************************
    // Request gating.
    // ************************************************************

    // A disabled source is masked so it never asks for service.
    always_comb begin
        nxt_gated = src_req_i & enabled;
    end

    // Register read data and gated requests.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_ff <= `IPR_RD_IDLE;
            gated_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
            gated_ff <= nxt_gated;
        end
    end

    assign rdata_o     = rdata_ff;
    assign gated_req_o = gated_ff;

endmodule
`default_nettype wire

// ---- dv/ipr_top_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ********
// Port checker for the priority register.
// ********
module ipr_top_chk (
    input  wire logic              clk_i,      // Clock.
    input  wire logic              rst_b_i,    // Reset, low.
    input  wire ipr_pkg::ipr_bus_t bus_i,      // Request.
    input  wire logic [15:0]       rdata_o,    // Read data.
    input  wire ipr_pkg::ipr_prio_t prio_o,    // Levels.
    input  wire logic [2:0]        enabled_o,  // Live sources.
    input  wire logic [2:0]        src_req_i,  // Raw requests.
    input  wire logic [2:0]        gated_req_o // Gated requests.
);
    import ipr_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic        wr0;
    logic [15:0] word;
    // Write decode and the word that a read should return.
    assign wr0 = bus_i.wr && bus_i.addr == 4'h0;
    assign word = {5'h0, prio_o[8:6], 1'b0, prio_o[5:3], 1'b0, prio_o[2:0]};
    a_dma_field: assert property (
        wr0 |=> prio_o[8:6] == $past(bus_i.wdata[10:8])) else $error("dma");
    a_adc_field: assert property (
        wr0 |=> prio_o[5:3] == $past(bus_i.wdata[6:4])) else $error("adc");
    a_ser_field: assert property (
        wr0 |=> prio_o[2:0] == $past(bus_i.wdata[2:0])) else $error("ser");
    a_read_word: assert property (
        bus_i.rd && bus_i.addr == 4'h0 |=> rdata_o == $past(word))
        else $error("read word");
    a_reset_level: assert property (
        $rose(rst_b_i) |-> prio_o == 9'h124) else $error("reset level");
    a_level_enable: assert property (
        enabled_o == {|prio_o[8:6], |prio_o[5:3], |prio_o[2:0]})
        else $error("enable");
    a_gate_req: assert property (
        1'b1 |=> gated_req_o == $past(src_req_i & enabled_o))
        else $error("gating");
    a_hold_prio: assert property (
        !wr0 |=> $stable(prio_o)) else $error("level moved");
    a_stat_enable: assert property (
        bus_i.rd && bus_i.addr == 4'h1 |=> rdata_o[2:0] == $past(enabled_o))
        else $error("status enable");
    c_all_ones: cover property (wr0 && bus_i.wdata[2:0] == 3'h7);
    c_read: cover property (bus_i.rd ##1 rdata_o != 16'h0);
    c_masked: cover property (src_req_i != 3'h0 && enabled_o != 3'h7);
    c_status: cover property (bus_i.rd && bus_i.addr == 4'h1);
endmodule
bind ipr_top ipr_top_chk chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .prio_o(prio_o),
    .enabled_o(enabled_o), .src_req_i(src_req_i),
    .gated_req_o(gated_req_o));
`default_nettype wire

// ---- dv/tb_ipr_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ********
// Bench for the priority register.
// ********
module tb_ipr_top;
    import ipr_pkg::*;
    typedef struct {
        logic [15:0] wd;
        logic [15:0] rd;
        logic [2:0]  en;
    } ipr_row_t;
    logic        clk_i;
    logic        rst_b_i;
    ipr_bus_t    bus;
    logic [15:0] rdata;
    ipr_prio_t   prio;
    logic [2:0]  en;
    logic [2:0]  req;
    logic [2:0]  gated;
    int          err_total = 0;
    int          num_checks = 0;
    int          cyc = 0;
    ipr_row_t    rows[6] = '{'{16'hffff, 16'h0777, 3'h7},
        '{16'h0701, 16'h0701, 3'h5}, '{16'h0888, 16'h0000, 3'h0},
        '{16'h0100, 16'h0100, 3'h4}, '{16'h0010, 16'h0010, 3'h2},
        '{16'h0123, 16'h0123, 3'h7}};
    ipr_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus),
        .rdata_o(rdata), .prio_o(prio), .enabled_o(en), .src_req_i(req),
        .gated_req_o(gated));
    // Compares one value and counts the outcome.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Issues a one-cycle write; the next access clears the strobe.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
    endtask
    // Reads one word and checks it in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        bus <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge clk_i);
        bus <= '{4'h0, 16'h0, 1'b0, 1'b0};
        @(negedge clk_i);
        chk(rdata, exp);
        @(posedge clk_i);
    endtask
    // Prints the verdict and ends the run.
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Clock at 20 MHz.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Cuts a hang short.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_total++;
            final_report();
        end
    end
    // Table run, then reset and refusal cases.
    initial begin
        rst_b_i = 1'b0;
        bus = '0;
        req = 3'h7;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd(4'h0, 16'h0444);
        chk({13'h0, en}, 16'h0007);
        foreach (rows[i]) begin
            wr(4'h0, rows[i].wd);
            rd(4'h0, rows[i].rd);
            chk({7'h0, prio}, {7'h0, rows[i].rd[10:8], rows[i].rd[6:4],
                rows[i].rd[2:0]});
            chk({13'h0, en}, {13'h0, rows[i].en});
            chk({13'h0, gated}, {13'h0, rows[i].en});
        end
        wr(4'h1, 16'h0000);
        rd(4'h0, 16'h0123);
        rd(4'h2, 16'h0000);
        // Status word: a disabled source that asks is masked, then live ones that ask pass.
        wr(4'h0, 16'h0701);
        bus <= '{4'h0, 16'h0, 1'b0, 1'b0};
        req <= 3'h2;
        @(posedge clk_i);
        rd(4'h1, 16'h0025);
        chk({13'h0, gated}, 16'h0000);
        req <= 3'h5;
        @(posedge clk_i);
        rd(4'h1, 16'h0555);
        wr(4'h0, 16'h0555);
        bus <= '{4'h0, 16'h0, 1'b0, 1'b0};
        rst_b_i <= 1'b0;
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd(4'h0, 16'h0444);
        final_report();
    end
endmodule
`default_nettype wire
